// >>> pat_pkg.sv
// Constants and types for the page address translator
package pat_pkg;
   localparam int ADDR_W = 24;
   localparam int IO_ADDR_W = 16;
   localparam int PAGE_W = 10;
   localparam int NUM_PAGES = 64;
   localparam int IDX_W = 6;
   localparam int ATR_W = 11;
   localparam int PGE_BIT = 10;
   // Configuration indexes
   localparam logic [7:0] IDX_SHADOW_EN1 = 8'h0C;
   localparam logic [7:0] IDX_SHADOW_EN2 = 8'h0D;
   localparam logic [7:0] IDX_SHADOW_EN3 = 8'h0E;
   localparam logic [7:0] IDX_SHADOW_PR1 = 8'h0F;
   localparam logic [7:0] IDX_SHADOW_PR2 = 8'h10;
   localparam logic [7:0] IDX_SHADOW_PR3 = 8'h11;
   localparam logic [7:0] IDX_IO_LOCATION = 8'h18;
   localparam logic [7:0] IDX_MAP_SPACE = 8'h25;
   localparam logic [7:0] IDX_DRAM_RELOC = 8'h26;
   // Field positions
   localparam int LOC_NIB_LSB = 0;
   localparam int LOC_IO_EN_BIT = 4;
   localparam int MSC_SIZE_LSB = 0;
   localparam int MSC_SIZE_W = 5;
   localparam int MSC_UPPER_BIT = 6;
   localparam int REL_BIT = 0;
   localparam int WIN_ALT_BIT = 6;
   localparam int WIN_GTE_BIT = 7;
   // I/O window decode: slot in bits 15:14, location nibble in 7:4
   localparam logic [3:0] IO_HI_NIB = 4'h2;
   localparam logic [3:0] IO_SLOT_LO = 4'h8;
   localparam logic [3:0] IO_CTRL_LO = 4'h9;
   localparam logic [5:0] IO_CTRL_TOP = 6'h00;
   // Memory map
   localparam logic [ADDR_W-1:0] REAL_LIMIT = 24'h100000;
   localparam logic [ADDR_W-1:0] UPPER_BASE = 24'h0A0000;
   localparam logic [ADDR_W-1:0] RELOC_BASE = 24'h100000;
   localparam int RELOC_KB = 384;
   localparam int MAP_UNIT_SHIFT = 19;
   localparam int PAGE_SHIFT = 14;
   localparam int UPPER_FIRST_PAGE = 40;
   localparam int SHADOW_BLOCKS = 24;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// >>> pat_page_lookup.sv
// Page translation lookup for one address
`timescale 1ns/1ps
`default_nettype none
module pat_page_lookup (
   // Address in
   input wire logic [pat_pkg::ADDR_W-1:0] addr_in,
   input wire logic [pat_pkg::ATR_W-1:0] entry_in,
   input wire logic enable_in,
   // Result
   output logic [pat_pkg::ADDR_W-1:0] addr_out,
   output logic hit_out
);
   import pat_pkg::*;
   always_comb begin
      hit_out = enable_in && entry_in[PGE_BIT] && (addr_in < REAL_LIMIT); // [RULE_17] [RULE_18]
      if (hit_out) begin
         addr_out = {entry_in[PAGE_W-1:0], addr_in[PAGE_SHIFT-1:0]}; // [RULE_18]
      end else begin
         addr_out = addr_in; // [RULE_19]
      end
   end
endmodule
`default_nettype wire

// >>> pat_top.sv
// Page address translator with translation register file and I/O window
// What this block does
// RULE_01 - Relocate 384 kb upper RAM to 100000h
// RULE_02 - Decode 24 shadow enable bits per block
// RULE_03 - Decode 24 shadow protect bits per block
// RULE_04 - Translate CPU, DMA and master addresses
// RULE_05 - Any page maps anywhere in map space
// RULE_06 - Map size field reserves size times 512kb
// RULE_07 - Reserved map space unreachable untranslated
// RULE_08 - Upper area used as map space
// RULE_09 - Software never combines relocation and upper map
// RULE_10 - Two sets of 64 translation registers
// RULE_11 - Register n covers page n
// RULE_12 - Four-slot window at control index
// RULE_13 - Control one above slot; location nibble
// RULE_14 - Slots at 02a8,42a8,82a8,C2a8; control 02a9
// RULE_15 - Window visible only with I/O enable
// RULE_16 - Alternate select switches access and translation
// RULE_17 - Global enable gates all translation
// RULE_18 - Page field replaces upper ten bits
// RULE_19 - Untranslated accesses pass unchanged
`timescale 1ns/1ps
`default_nettype none
module pat_top (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Configuration index port
   input wire logic cfg_wr_in,
   input wire logic [7:0] cfg_index_in,
   input wire logic [7:0] cfg_wdata_in,
   output logic [7:0] cfg_rdata_out,
   // I/O port
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic io_word_in,
   input wire logic [pat_pkg::IO_ADDR_W-1:0] io_addr_in,
   input wire logic [15:0] io_wdata_in,
   output logic [15:0] io_rdata_out,
   output logic io_hit_out,
   // Memory access from CPU, DMA or external master
   input wire logic [pat_pkg::ADDR_W-1:0] mem_addr_in,
   input wire logic mem_wr_in,
   input wire logic [pat_pkg::ADDR_W-1:0] local_top_in,
   output logic [pat_pkg::ADDR_W-1:0] mem_addr_out,
   output logic mem_block_out,
   output logic mem_shadow_out,
   output logic mem_protect_out
);
   import pat_pkg::*;
   logic [7:0] loc_reg, msc_reg, dcr_reg, ctrl_reg;
   logic [SHADOW_BLOCKS-1:0] shadow_en_reg, shadow_pr_reg;
   logic [ATR_W-1:0] main_set [NUM_PAGES];
   logic [ATR_W-1:0] alt_set [NUM_PAGES];
   logic [1:0] slot;
   logic io_vis, slot_sel, ctrl_sel;
   logic [IDX_W-1:0] win_idx;
   logic [IDX_W-1:0] page_idx;
   logic [ATR_W-1:0] entry;
   logic [ADDR_W-1:0] xl_addr, phys_next, map_base;
   logic xl_hit, in_upper, shadow_k, protect_k, block_next;
   logic [4:0] blk;
   ////////////////////////////////////////////////////////////////
   // I/O window decode
   assign io_vis = loc_reg[LOC_IO_EN_BIT]; // [RULE_15]
   assign slot = io_addr_in[15:14];
   assign slot_sel = io_vis && io_word_in && io_addr_in[13:8] == {IO_CTRL_TOP[1:0], IO_HI_NIB}
      && io_addr_in[7:4] == loc_reg[LOC_NIB_LSB +: 4] && io_addr_in[3:0] == IO_SLOT_LO; // [RULE_13] [RULE_14]
   assign ctrl_sel = io_vis && !io_word_in && io_addr_in[15:8] == {4'h0, IO_HI_NIB}
      && io_addr_in[7:4] == loc_reg[3:0] && io_addr_in[3:0] == IO_CTRL_LO; // [RULE_13] [RULE_14]
   assign win_idx = ctrl_reg[IDX_W-1:0] + IDX_W'(slot); // [RULE_12]
   ////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         loc_reg <= RST_BYTE;
         msc_reg <= RST_BYTE;
         dcr_reg <= RST_BYTE;
         shadow_en_reg <= '0;
         shadow_pr_reg <= '0;
      end else if (cfg_wr_in) begin
         unique case (cfg_index_in)
            IDX_IO_LOCATION: loc_reg <= cfg_wdata_in; // [RULE_15]
            IDX_MAP_SPACE: msc_reg <= cfg_wdata_in; // [RULE_06] [RULE_08]
            IDX_DRAM_RELOC: dcr_reg <= cfg_wdata_in; // [RULE_01]
            IDX_SHADOW_EN1: shadow_en_reg[7:0] <= cfg_wdata_in; // [RULE_02]
            IDX_SHADOW_EN2: shadow_en_reg[15:8] <= cfg_wdata_in;
            IDX_SHADOW_EN3: shadow_en_reg[23:16] <= cfg_wdata_in;
            IDX_SHADOW_PR1: shadow_pr_reg[7:0] <= cfg_wdata_in; // [RULE_03]
            IDX_SHADOW_PR2: shadow_pr_reg[15:8] <= cfg_wdata_in;
            IDX_SHADOW_PR3: shadow_pr_reg[23:16] <= cfg_wdata_in;
            default: ;
         endcase
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cfg_rdata_out <= RST_BYTE;
      end else begin
         unique case (cfg_index_in)
            IDX_IO_LOCATION: cfg_rdata_out <= loc_reg;
            IDX_MAP_SPACE: cfg_rdata_out <= msc_reg;
            IDX_DRAM_RELOC: cfg_rdata_out <= dcr_reg;
            IDX_SHADOW_EN1: cfg_rdata_out <= shadow_en_reg[7:0];
            IDX_SHADOW_EN2: cfg_rdata_out <= shadow_en_reg[15:8];
            IDX_SHADOW_EN3: cfg_rdata_out <= shadow_en_reg[23:16];
            IDX_SHADOW_PR1: cfg_rdata_out <= shadow_pr_reg[7:0];
            IDX_SHADOW_PR2: cfg_rdata_out <= shadow_pr_reg[15:8];
            IDX_SHADOW_PR3: cfg_rdata_out <= shadow_pr_reg[23:16];
            default: cfg_rdata_out <= RST_BYTE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////
   // Control register and translation register file
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ctrl_reg <= RST_BYTE; // [RULE_16]
      end else if (io_wr_in && ctrl_sel) begin
         ctrl_reg <= io_wdata_in[7:0]; // [RULE_12]
      end
   end
   // Page enable bits are left unreset, as software must initialise every entry
   always_ff @(posedge core_clk_in) begin
      if (io_wr_in && slot_sel) begin
         if (ctrl_reg[WIN_ALT_BIT]) begin
            alt_set[win_idx] <= io_wdata_in[ATR_W-1:0]; // [RULE_10] [RULE_16]
         end else begin
            main_set[win_idx] <= io_wdata_in[ATR_W-1:0]; // [RULE_10]
         end
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         io_rdata_out <= '0;
         io_hit_out <= 1'b0;
      end else begin
         io_hit_out <= (io_rd_in || io_wr_in) && (slot_sel || ctrl_sel);
         if (io_rd_in && slot_sel) begin
            io_rdata_out <= 16'(ctrl_reg[WIN_ALT_BIT] ? alt_set[win_idx] : main_set[win_idx]);
         end else if (io_rd_in && ctrl_sel) begin
            io_rdata_out <= {8'h00, ctrl_reg};
         end else begin
            io_rdata_out <= '0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // Address path
   assign page_idx = mem_addr_in[PAGE_SHIFT +: IDX_W]; // [RULE_11]
   assign entry = ctrl_reg[WIN_ALT_BIT] ? alt_set[page_idx] : main_set[page_idx]; // [RULE_16]
   pat_page_lookup u_lookup (
      .addr_in(mem_addr_in),
      .entry_in(entry),
      .enable_in(ctrl_reg[WIN_GTE_BIT]),
      .addr_out(xl_addr),
      .hit_out(xl_hit)
   ); // [RULE_04] [RULE_05]
   assign in_upper = mem_addr_in >= UPPER_BASE && mem_addr_in < REAL_LIMIT;
   assign blk = 5'(page_idx - IDX_W'(UPPER_FIRST_PAGE));
   assign shadow_k = in_upper && shadow_en_reg[blk]; // [RULE_02]
   assign protect_k = in_upper && shadow_pr_reg[blk]; // [RULE_03]
   assign map_base = local_top_in - (ADDR_W'(msc_reg[MSC_SIZE_W-1:0]) << MAP_UNIT_SHIFT); // [RULE_06]
   always_comb begin
      phys_next = xl_addr;
      block_next = 1'b0;
      if (!xl_hit && in_upper && !shadow_k && dcr_reg[REL_BIT] && !msc_reg[MSC_UPPER_BIT]) begin
         phys_next = mem_addr_in - UPPER_BASE + RELOC_BASE; // [RULE_01] [RULE_09]
      end
      if (!xl_hit && msc_reg[MSC_SIZE_W-1:0] != '0 && mem_addr_in >= map_base) begin
         block_next = 1'b1; // [RULE_07]
      end
      if (!xl_hit && in_upper && !shadow_k && msc_reg[MSC_UPPER_BIT]) begin
         block_next = 1'b1; // [RULE_08] [RULE_07]
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mem_addr_out <= '0;
         mem_block_out <= 1'b0;
         mem_shadow_out <= 1'b0;
         mem_protect_out <= 1'b0;
      end else begin
         mem_addr_out <= phys_next; // [RULE_04] [RULE_19]
         mem_block_out <= block_next;
         mem_shadow_out <= shadow_k;
         mem_protect_out <= protect_k && mem_wr_in;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Checks
   a_ctrl_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      io_wr_in && ctrl_sel |=> ctrl_reg == $past(io_wdata_in[7:0])) else $error("control write lost"); // [RULE_12]
   a_io_hidden: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !loc_reg[LOC_IO_EN_BIT] |=> !io_hit_out) else $error("window visible while disabled"); // [RULE_15]
   a_pass_through: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !ctrl_reg[WIN_GTE_BIT] && mem_addr_in < UPPER_BASE |=> mem_addr_out == $past(mem_addr_in))
      else $error("address changed without translation"); // [RULE_19]
   a_page_replace: assert property (@(posedge core_clk_in) disable iff (rst_in)
      xl_hit |=> mem_addr_out[PAGE_SHIFT-1:0] == $past(mem_addr_in[PAGE_SHIFT-1:0])
      && mem_addr_out[ADDR_W-1:PAGE_SHIFT] == $past(entry[PAGE_W-1:0])) else $error("bad page translation"); // [RULE_18]
   a_gte_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !ctrl_reg[WIN_GTE_BIT] |-> !xl_hit) else $error("translation without global enable"); // [RULE_17]
   a_reloc: assert property (@(posedge core_clk_in) disable iff (rst_in)
      dcr_reg[REL_BIT] && !msc_reg[MSC_UPPER_BIT] && !xl_hit && in_upper && !shadow_k
      |=> mem_addr_out == $past(mem_addr_in) + 24'h060000) else $error("relocation wrong"); // [RULE_01]
   a_map_block: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !xl_hit && msc_reg[4:0] != 5'h00 && mem_addr_in >= map_base |=> mem_block_out)
      else $error("map space reachable"); // [RULE_07]
   a_protect: assert property (@(posedge core_clk_in) disable iff (rst_in)
      mem_wr_in && mem_addr_in[23:14] == 10'h028 && shadow_pr_reg[0] |=> mem_protect_out)
      else $error("protect bit 0 not decoded"); // [RULE_03]
   a_shadow_top: assert property (@(posedge core_clk_in) disable iff (rst_in)
      mem_addr_in[23:14] == 10'h03F && shadow_en_reg[23] |=> mem_shadow_out)
      else $error("shadow bit 23 not decoded"); // [RULE_02]
   c_translate: cover property (@(posedge core_clk_in) xl_hit);
   c_alt_translate: cover property (@(posedge core_clk_in) xl_hit && ctrl_reg[WIN_ALT_BIT]);
   c_window_write: cover property (@(posedge core_clk_in) io_wr_in && slot_sel && slot == 2'd3);
   c_relocate: cover property (@(posedge core_clk_in) dcr_reg[REL_BIT] && in_upper);
endmodule
`default_nettype wire

// >>> pat_bus_master.sv
// Memory requester model standing in for the processor, DMA and external masters
`timescale 1ns/1ps
`default_nettype none
module pat_bus_master (
   // Clock
   input wire logic core_clk_in,
   // Access request
   output logic [pat_pkg::ADDR_W-1:0] mem_addr_out,
   output logic mem_wr_out
);
   import pat_pkg::*;
   initial begin
      mem_addr_out = 24'h000000;
      mem_wr_out = 1'b0;
   end
   // One access, launched after an edge and held through the next
   task automatic access(input logic [ADDR_W-1:0] addr, input logic wr);
      @(posedge core_clk_in);
      mem_addr_out <= addr;
      mem_wr_out <= wr;
      @(posedge core_clk_in);
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the page address translator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; \
   if ((g) !== (e)) begin $display("ERROR %s exp %h got %h", n, e, g); \
   fail_count++; end end
module tb;
   import pat_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, io_wr = 1'b0, io_rd = 1'b0, io_word = 1'b0;
   logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
   logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata;
   logic io_hit, mem_wr, mem_block, mem_shadow, mem_protect;
   logic [ADDR_W-1:0] mem_addr, mem_addr_out;
   logic [ADDR_W-1:0] local_top = 24'h400000;
   int fail_count = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   pat_bus_master i_master (.core_clk_in(clk), .mem_addr_out(mem_addr), .mem_wr_out(mem_wr));
   pat_top i_dut (.core_clk_in(clk), .rst_in(rst), .cfg_wr_in(cfg_wr), .cfg_index_in(cfg_index),
      .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata), .io_wr_in(io_wr), .io_rd_in(io_rd),
      .io_word_in(io_word), .io_addr_in(io_addr), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
      .io_hit_out(io_hit), .mem_addr_in(mem_addr), .mem_wr_in(mem_wr), .local_top_in(local_top),
      .mem_addr_out(mem_addr_out), .mem_block_out(mem_block), .mem_shadow_out(mem_shadow),
      .mem_protect_out(mem_protect));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cw(input logic [7:0] idx, input logic [7:0] val);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_index <= idx;
      cfg_wdata <= val;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask
   task automatic cr(input logic [7:0] idx, input logic [7:0] ex);
      @(posedge clk);
      cfg_index <= idx;
      @(posedge clk);
      #1 `CHK("cfg_rdata", ex, cfg_rdata)
   endtask
   task automatic io(input logic wr, input logic word, input logic [15:0] a, input logic [15:0] d,
      input logic hit, input logic [15:0] rd);
      logic [15:0] got;
      @(posedge clk);
      io_wr <= wr;
      io_rd <= !wr;
      io_word <= word;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      #1 `CHK("io_hit", hit, io_hit)
      got = word ? io_rdata : (io_rdata & 16'h00FF);
      if (!wr) `CHK("io_rdata", rd, got)
   endtask
   task automatic mc(input logic [23:0] a, input logic wr, input logic [23:0] ea, input logic [2:0] ef);
      logic [2:0] f;
      i_master.access(a, wr);
      #1 f = {mem_block, mem_shadow, mem_protect};
      `CHK("mem_addr_out", ea, mem_addr_out)
      `CHK("block_shadow_protect", ef, f)
   endtask
   // Fill one whole set; entry 0 and entry 63 get the given values, the rest page disabled
   task automatic prog(input logic [7:0] sel, input logic [10:0] e0, input logic [10:0] e63);
      for (int w = 0; w < 16; w++) begin
         io(1'b1, 1'b0, 16'h0209, {8'h00, sel | 8'(w * 4)}, 1'b1, 16'h0000);
         for (int s = 0; s < 4; s++) begin
            io(1'b1, 1'b1, {2'(s), 14'h0208}, {5'h00, (w * 4 + s == 0) ? e0 : (w * 4 + s == 63) ? e63 : 11'h000},
               1'b1, 16'h0000);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cr(IDX_IO_LOCATION, 8'h00);
      cr(IDX_MAP_SPACE, 8'h00);
      cr(IDX_DRAM_RELOC, 8'h00);
      io(1'b1, 1'b0, 16'h0209, 16'h0080, 1'b0, 16'h0000);
      mc(24'h000002, 1'b0, 24'h000002, 3'b000);
      cw(IDX_IO_LOCATION, 8'h10);
      prog(8'h00, 11'h402, 11'h4FF);
      prog(8'h40, 11'h403, 11'h400);
      io(1'b1, 1'b0, 16'h0209, 16'h003E, 1'b1, 16'h0000);
      io(1'b0, 1'b1, 16'h8208, 16'h0000, 1'b1, 16'h0402);
      io(1'b0, 1'b1, 16'h4208, 16'h0000, 1'b1, 16'h04FF);
      io(1'b0, 1'b0, 16'h0209, 16'h0000, 1'b1, 16'h003E);
      io(1'b0, 1'b1, 16'h0209, 16'h0000, 1'b0, 16'h0000);
      io(1'b0, 1'b0, 16'h0208, 16'h0000, 1'b0, 16'h0000);
      io(1'b1, 1'b0, 16'h0209, 16'h007E, 1'b1, 16'h0000);
      io(1'b0, 1'b1, 16'h8208, 16'h0000, 1'b1, 16'h0403);
      cw(IDX_IO_LOCATION, 8'h1A);
      io(1'b0, 1'b0, 16'h02A9, 16'h0000, 1'b1, 16'h007E);
      io(1'b0, 1'b0, 16'h0209, 16'h0000, 1'b0, 16'h0000);
      io(1'b1, 1'b0, 16'h02A9, 16'h0080, 1'b1, 16'h0000);
      cw(IDX_MAP_SPACE, 8'h01);
      mc(24'h000002, 1'b0, 24'h008002, 3'b000);
      mc(24'h004005, 1'b0, 24'h004005, 3'b000);
      mc(24'h0FC123, 1'b1, 24'h3FC123, 3'b000);
      mc(24'h380010, 1'b0, 24'h380010, 3'b100);
      mc(24'h37FFFF, 1'b0, 24'h37FFFF, 3'b000);
      io(1'b1, 1'b0, 16'h02A9, 16'h00C0, 1'b1, 16'h0000);
      mc(24'h000002, 1'b0, 24'h00C002, 3'b000);
      mc(24'h0FC123, 1'b0, 24'h000123, 3'b000);
      io(1'b1, 1'b0, 16'h02A9, 16'h0040, 1'b1, 16'h0000);
      mc(24'h000002, 1'b0, 24'h000002, 3'b000);
      cw(IDX_MAP_SPACE, 8'h00);
      mc(24'h380010, 1'b0, 24'h380010, 3'b000);
      cw(IDX_DRAM_RELOC, 8'h01);
      mc(24'h0A0010, 1'b0, 24'h100010, 3'b000);
      mc(24'h0FFFFF, 1'b0, 24'h15FFFF, 3'b000);
      mc(24'h09FFFF, 1'b0, 24'h09FFFF, 3'b000);
      cw(IDX_DRAM_RELOC, 8'h00);
      cw(IDX_SHADOW_EN1, 8'h01);
      cw(IDX_SHADOW_EN3, 8'h80);
      cw(IDX_SHADOW_PR3, 8'h80);
      mc(24'h0A0000, 1'b0, 24'h0A0000, 3'b010);
      mc(24'h0A4000, 1'b0, 24'h0A4000, 3'b000);
      mc(24'h0FC000, 1'b1, 24'h0FC000, 3'b011);
      mc(24'h0FC000, 1'b0, 24'h0FC000, 3'b010);
      cw(IDX_SHADOW_PR1, 8'h01);
      mc(24'h0A0000, 1'b1, 24'h0A0000, 3'b011);
      cw(IDX_MAP_SPACE, 8'h40); // Relocation already off
      cr(IDX_MAP_SPACE, 8'h40);
      mc(24'h0A4000, 1'b0, 24'h0A4000, 3'b100);
      mc(24'h0A0000, 1'b0, 24'h0A0000, 3'b010);
      end_of_test();
   end
endmodule
`default_nettype wire
